// ### i2cpg_pkg.sv
/*
 * Shared constants and types for the configuration-port page select block.
 * Assumes the i2c pins are already synchronous to the system clock.
 */
package i2cpg_pkg;
    localparam logic [7:0] MAP_PAGE_CONTROL_OFFS  = 8'h0E;
    localparam logic [7:0] MAP_PAGE_CONTROL_RESET = 8'h00;
    localparam int         PAGE_LSB               = 5;
    localparam int         PAGE_MSB               = 6;
    localparam logic [1:0] PAGE_USER              = 2'h0;
    localparam logic [1:0] PAGE_VBI               = 2'h1;
    localparam logic [1:0] PAGE_USER2             = 2'h2;
    localparam logic [1:0] PAGE_NONE              = 2'h3;
    localparam logic [1:0] POST_MAP_INDEX         = 2'h3;
    localparam logic [7:0] MAIN_WR_ADDR_BASE      = 8'h40;
    localparam logic [7:0] POST_WR_ADDR           = 8'h84;
    localparam int         STRAP_ADDR_BIT         = 1;
    localparam int         MAIN_DEPTH_DEFAULT     = 256;
    localparam int         POST_DEPTH_DEFAULT     = 128;
    localparam logic [3:0] BITS_PER_BYTE          = 4'h8;

    typedef enum logic [2:0] {
        ENG_IDLE,
        ENG_RX,
        ENG_ACK,
        ENG_TX,
        ENG_MACK
    } i2cpg_eng_state_t;

    typedef enum logic [1:0] {
        SES_IDLE,
        SES_SUB,
        SES_DATA,
        SES_READ
    } i2cpg_ses_state_t;
endpackage

// ### i2cpg_byte_if.sv
/*
 * Byte-level carrier between the bit engine and the register side.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps
interface i2cpg_byte_if;
    logic       start;
    logic       stop;
    logic       rx_valid;
    logic       rx_first;
    logic [7:0] rx_data;
    logic       tx_done;
    logic       sda_oe;
    logic       ack;
    logic [7:0] tx_data;

    modport engine (output start, stop, rx_valid, rx_first, rx_data, tx_done, sda_oe,
                    input  ack, tx_data);
    modport regs   (input  start, stop, rx_valid, rx_first, rx_data, tx_done, sda_oe,
                    output ack, tx_data);
endinterface

// ### i2cpg_byte_engine.sv
/*
 * i2c slave bit engine: start/stop detection, byte shifting, acknowledge
 * and read-data drive. Assumes scl/sda sampled synchronously, and that the
 * register side answers ack within one clock of rx_valid.
 */
`timescale 1ns/100ps
module i2cpg_byte_engine
    import i2cpg_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_n_i,
    input  wire logic    scl_i,
    input  wire logic    sda_i,
    i2cpg_byte_if.engine bus
);
    logic             scl_q;
    logic             sda_q;
    i2cpg_eng_state_t state;
    logic [3:0]       bit_cnt;
    logic [7:0]       shreg;
    logic             first;
    logic             rd;
    logic             mack;

    wire start_cond = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_cond  = scl_i & scl_q & ~sda_q & sda_i;
    wire scl_rise   = scl_i & ~scl_q;
    wire scl_fall   = ~scl_i & scl_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // start and stop win at any stage: stop falls back to idle, start restarts address reception
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= ENG_IDLE;
            bit_cnt    <= 4'h0;
            shreg      <= 8'h00;
            first      <= 1'b0;
            rd         <= 1'b0;
            mack       <= 1'b0;
            bus.sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state      <= ENG_IDLE;
            bus.sda_oe <= 1'b0;
        end else if (start_cond) begin
            state      <= ENG_RX;
            bit_cnt    <= 4'h0;
            first      <= 1'b1;
            rd         <= 1'b0;
            bus.sda_oe <= 1'b0;
        end else begin
            case (state)
                ENG_RX: begin
                    if (scl_rise && bit_cnt != BITS_PER_BYTE) begin
                        shreg   <= {shreg[6:0], sda_i};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
                        if (bus.ack) begin
                            bus.sda_oe <= 1'b1;
                            state      <= ENG_ACK;
                            if (first) begin
                                rd <= shreg[0];
                            end
                        end else begin
                            state <= ENG_IDLE;
                        end
                    end
                end
                ENG_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        first   <= 1'b0;
                        if (rd) begin
                            shreg      <= bus.tx_data;
                            bus.sda_oe <= ~bus.tx_data[7];
                            state      <= ENG_TX;
                        end else begin
                            bus.sda_oe <= 1'b0;
                            state      <= ENG_RX;
                        end
                    end
                end
                ENG_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
                            bus.sda_oe <= 1'b0;
                            state      <= ENG_MACK;
                        end else begin
                            shreg      <= {shreg[6:0], 1'b0};
                            bus.sda_oe <= ~shreg[6];
                            bit_cnt    <= bit_cnt + 4'h1;
                        end
                    end
                end
                ENG_MACK: begin
                    if (scl_rise) begin
                        mack <= ~sda_i;
                    end else if (scl_fall) begin
                        if (mack) begin
                            bit_cnt    <= 4'h0;
                            shreg      <= bus.tx_data;
                            bus.sda_oe <= ~bus.tx_data[7];
                            state      <= ENG_TX;
                        end else begin
                            state <= ENG_IDLE;
                        end
                    end
                end
                default: state <= ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus.rx_valid <= 1'b0;
            bus.rx_first <= 1'b0;
            bus.rx_data  <= 8'h00;
            bus.tx_done  <= 1'b0;
            bus.start    <= 1'b0;
            bus.stop     <= 1'b0;
        end else begin
            bus.rx_valid <= (state == ENG_RX) && scl_rise && bit_cnt == BITS_PER_BYTE - 4'h1 && !start_cond
                            && !stop_cond;
            bus.rx_first <= first;
            if ((state == ENG_RX) && scl_rise && bit_cnt == BITS_PER_BYTE - 4'h1) begin
                bus.rx_data <= {shreg[6:0], sda_i};
            end
            bus.tx_done <= (state == ENG_MACK) && scl_rise && !sda_i;
            bus.start   <= start_cond;
            bus.stop    <= stop_cond;
        end
    end
endmodule

// ### i2cpg_top.sv
/*
 * Configuration port with main-map paging and postprocessor map decode.
 * Holds the register storage, slave address decode and subaddress walk.
 * Assumes scl/sda/strap are synchronous to clk_i; sda is open drain,
 * resolved outside from sda_oe_o.
 */
`timescale 1ns/100ps
module i2cpg_top
    import i2cpg_pkg::*;
#(
    parameter int unsigned MAIN_DEPTH = MAIN_DEPTH_DEFAULT,
    parameter int unsigned POST_DEPTH = POST_DEPTH_DEFAULT
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       addr_select_strap_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic [1:0]      map_page_select_o
);
    logic [1:0]       rst_sync;
    logic             rst_n;
    i2cpg_byte_if     bus ();
    i2cpg_ses_state_t phase;
    logic             tgt_post;
    logic [7:0]       sub;
    logic             over;
    logic [7:0]       map_page_control;
    logic [7:0]       mem [0:3][0:255];
    logic             hit_main;
    logic             hit_post;
    logic             wr_en;
    logic [7:0]       sub_inc;
    logic             sub_inc_ok;
    logic [1:0]       page;

    // reset is released through two flops so every block leaves reset together
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    i2cpg_byte_engine u_engine (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .bus     (bus)
    );

    // open drain: the data level is always low, only the enable moves
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end
    assign sda_oe_o          = bus.sda_oe;
    assign page              = map_page_control[PAGE_MSB:PAGE_LSB];
    assign map_page_select_o = page;

    function automatic logic sub_ok(input logic post, input logic [7:0] s);
        if (post) begin
            sub_ok = {1'b0, s} < 9'(POST_DEPTH);
        end else if (page == PAGE_NONE) begin
            sub_ok = (s == MAP_PAGE_CONTROL_OFFS); // only the way back out stays reachable
        end else begin
            sub_ok = {1'b0, s} < 9'(MAIN_DEPTH);
        end
    endfunction

    function automatic logic [7:0] rd_val(input logic post, input logic [7:0] s);
        if (post) begin
            rd_val = mem[POST_MAP_INDEX][s];
        end else if (s == MAP_PAGE_CONTROL_OFFS) begin
            rd_val = map_page_control;
        end else if (page == PAGE_NONE) begin
            rd_val = 8'h00; // code 11 would alias the postprocessor store
        end else begin
            rd_val = mem[page][s];
        end
    endfunction

    // page field never alters the slave addresses
    assign hit_main   = bus.rx_data[7:2] == MAIN_WR_ADDR_BASE[7:2]
                        && bus.rx_data[STRAP_ADDR_BIT] == addr_select_strap_i;
    assign hit_post   = bus.rx_data[7:1] == POST_WR_ADDR[7:1];
    assign sub_inc    = sub + 8'h01;
    assign sub_inc_ok = (sub != 8'hFF) && sub_ok(tgt_post, sub_inc);
    assign wr_en      = bus.rx_valid && !bus.rx_first && phase == SES_DATA && !over;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            phase       <= SES_IDLE;
            tgt_post    <= 1'b0;
            sub         <= 8'h00;
            over        <= 1'b0;
            bus.ack     <= 1'b0;
            bus.tx_data <= 8'h00;
        end else if (bus.start || bus.stop) begin
            phase   <= SES_IDLE;
            bus.ack <= 1'b0;
        end else if (bus.rx_valid && bus.rx_first) begin
            bus.ack  <= hit_main || hit_post;
            tgt_post <= hit_post;
            if (!(hit_main || hit_post)) begin
                phase <= SES_IDLE;
            end else if (bus.rx_data[0]) begin
                phase       <= SES_READ;
                bus.tx_data <= rd_val(hit_post, sub);
            end else begin
                phase <= SES_SUB;
            end
        end else if (bus.rx_valid) begin
            case (phase)
                SES_SUB: begin
                    sub     <= bus.rx_data;
                    over    <= 1'b0;
                    bus.ack <= sub_ok(tgt_post, bus.rx_data);
                    phase   <= sub_ok(tgt_post, bus.rx_data) ? SES_DATA : SES_IDLE;
                end
                SES_DATA: begin
                    bus.ack <= !over;
                    if (over) begin
                        phase <= SES_IDLE; // byte past the top is dropped and refused
                    end else if (sub_inc_ok) begin
                        sub <= sub_inc;
                    end else begin
                        over <= 1'b1;
                    end
                end
                default: begin
                    bus.ack <= 1'b0;
                end
            endcase
        end else if (bus.tx_done && phase == SES_READ) begin
            // at the top of the map the last register repeats until the master nacks
            if (sub_inc_ok) begin
                sub         <= sub_inc;
                bus.tx_data <= rd_val(tgt_post, sub_inc);
            end else begin
                bus.tx_data <= rd_val(tgt_post, sub);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            map_page_control <= MAP_PAGE_CONTROL_RESET;
        end else if (wr_en && !tgt_post && sub == MAP_PAGE_CONTROL_OFFS) begin
            map_page_control <= bus.rx_data;
        end
    end

    // storage is cleared at reset so reads never return unknowns
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < 4; m++) begin
                for (int a = 0; a < 256; a++) begin
                    mem[m][a] <= 8'h00;
                end
            end
        end else if (wr_en && tgt_post) begin
            mem[POST_MAP_INDEX][sub] <= bus.rx_data;
        end else if (wr_en && sub != MAP_PAGE_CONTROL_OFFS && page != PAGE_NONE) begin
            // a write that slips into page 11 is dropped, not aliased
            mem[page][sub] <= bus.rx_data;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_addr_byte;
        bus.rx_valid && bus.rx_first;
    endsequence

    sequence s_sub_byte;
        bus.rx_valid && !bus.rx_first && phase == SES_SUB && !bus.start && !bus.stop;
    endsequence

    AST_PAGE_RESET: assert property (disable iff (1'b0) $rose(rst_n) |-> map_page_control == 8'h00)
        else $error("page field not 00 after reset");
    AST_ROUTE: assert property (wr_en && !tgt_post && sub != 8'h0E && page != 2'h3
        |=> mem[$past(page)][$past(sub)] == $past(bus.rx_data))
        else $error("main write not routed to selected sub map");
    AST_MAIN_ADDR: assert property (s_addr_byte ##0 (bus.rx_data[7:1] == {6'b010000, addr_select_strap_i})
        && !bus.start && !bus.stop |=> bus.ack && !tgt_post)
        else $error("main slave address not acknowledged");
    AST_POST_ADDR: assert property (s_addr_byte ##0 (bus.rx_data[7:1] == 7'h42)
        && !bus.start && !bus.stop |=> bus.ack && tgt_post)
        else $error("postprocessor address not acknowledged");
    AST_STRAP: assert property (s_addr_byte ##0 (bus.rx_data[7:1] == {6'b010000, ~addr_select_strap_i})
        && !bus.start && !bus.stop |=> !bus.ack)
        else $error("address with wrong strap bit acknowledged");
    AST_READ_DIR: assert property (s_addr_byte ##0 (hit_main && bus.rx_data[0])
        && !bus.start && !bus.stop |=> phase == SES_READ)
        else $error("read bit did not start a read");
    AST_INCR: assert property (wr_en && sub_inc_ok && !bus.start && !bus.stop |=> sub == $past(sub) + 8'h01)
        else $error("subaddress did not advance after data byte");
    AST_BAD_SUB: assert property (s_sub_byte ##0 !sub_ok(tgt_post, bus.rx_data)
        |=> !bus.ack && phase == SES_IDLE)
        else $error("invalid subaddress acknowledged");
    AST_PAGE_NONE: assert property (wr_en && !tgt_post && page == 2'h3 |-> sub == 8'h0E)
        else $error("write reached undefined sub map");
endmodule

// ### i2cpg_master_model.sv
/*
 * Behavioural i2c host that drives the configuration port.
 * Assumes the bench resolves the open-drain data wire onto sda_i.
 */
`timescale 1ns/100ps
module i2cpg_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // four clocks a quarter keeps every scl phase well over three clocks
    localparam int QTR = 4;

    initial begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic wait_q();
        repeat (QTR) @(negedge clk_i);
    endtask

    // also a repeated start when entered with scl low
    task automatic start_cond();
        sda_low_o = 1'b0;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_low_o = 1'b1;
        wait_q();
        scl_o = 1'b0;
        wait_q();
    endtask

    task automatic stop_cond();
        sda_low_o = 1'b1;
        wait_q();
        scl_o = 1'b1;
        wait_q();
        sda_low_o = 1'b0;
        wait_q();
    endtask

    // nine slots msb first; a 1 releases the wire so the slave may pull it
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o = ~tx[i];
            wait_q();
            scl_o = 1'b1;
            wait_q();
            rx[i] = sda_i;
            wait_q();
            scl_o = 1'b0;
            wait_q();
        end
    endtask
endmodule

// ### i2c_register_map_page_select_tb.sv
/*
 * Self-checking bench for the page select block.
 * Assumes the host model in i2cpg_master_model and a pulled-up sda wire.
 */
`timescale 1ns/100ps
module i2c_register_map_page_select_tb
    import i2cpg_pkg::*;
;
    localparam logic [7:0] MW = MAIN_WR_ADDR_BASE;
    localparam logic [7:0] PW = POST_WR_ADDR;
    localparam logic [7:0] PC = MAP_PAGE_CONTROL_OFFS;
    logic       clk_i;
    logic       rst_n_i;
    logic       strap;
    logic       scl;
    logic       sda_low;
    logic       sda;
    logic       sda_o;
    logic       sda_oe_o;
    logic [1:0] page;
    int         failures;
    int         n_checks;

    // pull-up: high unless some party pulls low
    assign sda = ~(sda_low | (sda_oe_o & ~sda_o));

    i2cpg_top #(.MAIN_DEPTH(256), .POST_DEPTH(128)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
        .addr_select_strap_i(strap), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .map_page_select_o(page));
    i2cpg_master_model host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apply_reset();
        rst_n_i = 1'b0;
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask

    // acks shift in, address first
    task automatic wr(input logic [7:0] ad, input logic [7:0] sub, input logic [23:0] dat, input int n,
                      output logic [7:0] acks);
        logic [8:0] r;
        acks = 8'h00;
        host.start_cond();
        host.byte_io({ad, 1'b1}, r);
        acks = {acks[6:0], ~r[0]};
        host.byte_io({sub, 1'b1}, r);
        acks = {acks[6:0], ~r[0]};
        for (int i = n - 1; i >= 0; i--) begin
            host.byte_io({dat[8*i+:8], 1'b1}, r);
            acks = {acks[6:0], ~r[0]};
        end
        host.stop_cond();
    endtask

    // host acks every byte but the last
    task automatic rd(input logic [7:0] ad, input logic [7:0] sub, input int n, output logic [23:0] d);
        logic [8:0] r;
        d = 24'h000000;
        host.start_cond();
        host.byte_io({ad, 1'b1}, r);
        host.byte_io({sub, 1'b1}, r);
        host.start_cond();
        host.byte_io({ad | 8'h01, 1'b1}, r);
        for (int i = n - 1; i >= 0; i--) begin
            host.byte_io({8'hFF, i == 0}, r);
            d = {d[15:0], r[8:1]};
        end
        host.stop_cond();
    endtask

    task automatic t_reset();
        logic [7:0]  a;
        logic [23:0] d;
        check(page, PAGE_USER);
        rd(MW, PC, 1, d);
        check(d, MAP_PAGE_CONTROL_RESET);
        wr(MW, PC, 24'h20, 1, a);
        check(page, PAGE_VBI);
        apply_reset();
        check(page, PAGE_USER);
        $display("test reset done");
    endtask

    task automatic t_decode();
        logic [7:0] ad [6];
        logic [8:0] r;
        logic       ack;
        ad = '{8'h40, 8'h42, 8'h84, 8'h86, 8'h44, 8'hC2};
        for (int s = 0; s < 2; s++) begin
            @(negedge clk_i);
            strap = s[0];
            for (int k = 0; k < 6; k++) begin
                host.start_cond();
                host.byte_io({ad[k], 1'b1}, r);
                host.stop_cond();
                ack = ~r[0];
                check(ack, (k == 2) || (k == s));
            end
        end
        $display("test decode done");
    endtask

    task automatic t_page();
        logic [7:0]  a;
        logic [23:0] d;
        logic [7:0]  m2;
        m2 = MW | 8'h02;
        @(negedge clk_i);
        strap = 1'b1;
        for (int p = 0; p < 3; p++) begin
            wr(m2, PC, 24'(p << PAGE_LSB), 1, a);
            check(page, p[1:0]);
            wr(m2, 8'h10, 24'(8'hA0 + p), 1, a);
            check(a, 8'h07);
        end
        for (int p = 0; p < 3; p++) begin
            wr(m2, PC, 24'(p << PAGE_LSB), 1, a);
            rd(m2, 8'h10, 1, d);
            check(d, 24'(8'hA0 + p));
        end
        wr(PW, 8'h10, 24'h5C, 1, a);
        check(a, 8'h07);
        rd(PW, 8'h10, 1, d);
        check(d, 24'h5C);
        wr(m2, PC, 24'h00, 1, a);
        check(page, PAGE_USER);
        @(negedge clk_i);
        strap = 1'b0;
        wr(MW, PC, 24'h60, 1, a);
        check(page, PAGE_NONE);
        wr(MW, 8'h10, 24'h77, 1, a);
        check(a, 8'h04);
        rd(MW, PC, 1, d);
        check(d, 24'h60);
        rd(MW, 8'h10, 1, d);
        check(d, 24'h00);
        wr(MW, PC, 24'h00, 1, a);
        rd(MW, 8'h10, 1, d);
        check(d, 24'hA0);
        $display("test page done");
    endtask

    task automatic t_autoinc();
        logic [7:0]  a;
        logic [23:0] d;
        wr(MW, 8'h20, 24'h112233, 3, a);
        check(a, 8'h1F);
        rd(MW, 8'h20, 3, d);
        check(d, 24'h112233);
        rd(MW, 8'h22, 1, d);
        check(d, 24'h33);
        wr(PW, 8'h7E, 24'hA1B2C3, 3, a);
        check(a, 8'h1E);
        rd(PW, 8'h7E, 3, d);
        check(d, 24'hA1B2B2);
        wr(PW, 8'h80, 24'h00, 1, a);
        check(a, 8'h04);
        $display("test autoinc done");
    endtask

    task automatic give_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // whole run needs about 18000 clocks
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        give_verdict();
    end

    initial begin
        strap    = 1'b0;
        failures = 0;
        n_checks = 0;
        apply_reset();
        t_reset();
        t_decode();
        t_page();
        t_autoinc();
        give_verdict();
    end
endmodule
